/* core/srad_consts.vh */
`ifndef SRAD_CONSTS_VH
`define SRAD_CONSTS_VH
// ----------------------------------------
// command byte layout
// ----------------------------------------
`define SRAD_CMD_ADDR        6'h00
`define SRAD_CMD_RESET       8'h00
`define SRAD_CMD_GUARD_BIT   7
`define SRAD_CMD_DIR_BIT     6
`define SRAD_SEL_HI          5
`define SRAD_SEL_LO          0
// ----------------------------------------
// target select codes
// ----------------------------------------
`define SRAD_SEL_STATUS      6'h00
`define SRAD_SEL_ADCMODE     6'h01
`define SRAD_SEL_IFMODE      6'h02
`define SRAD_SEL_CHECKSUM    6'h03
`define SRAD_SEL_DATA        6'h04
`define SRAD_SEL_GPIO        6'h06
`define SRAD_SEL_ID          6'h07
`define SRAD_SEL_CH_BASE     4'h4
`define SRAD_SEL_SETUP_BASE  4'h8
`define SRAD_SEL_FILT_BASE   4'ha
`define SRAD_SEL_OFFS_BASE   4'hc
`define SRAD_SEL_GAIN_BASE   4'he
// ----------------------------------------
// status register
// ----------------------------------------
`define SRAD_STATUS_RESET    8'h80
`define SRAD_STATUS_WAIT_BIT 7
// ----------------------------------------
// decoded target classes (binary-encoded index)
// ----------------------------------------
`define SRAD_TGT_NONE        4'h0
`define SRAD_TGT_STATUS      4'h1
`define SRAD_TGT_ADCMODE     4'h2
`define SRAD_TGT_IFMODE      4'h3
`define SRAD_TGT_CHECKSUM    4'h4
`define SRAD_TGT_DATA        4'h5
`define SRAD_TGT_GPIO        4'h6
`define SRAD_TGT_ID          4'h7
`define SRAD_TGT_CHANNEL     4'h8
`define SRAD_TGT_SETUP       4'h9
`define SRAD_TGT_FILTER      4'ha
`define SRAD_TGT_OFFSET      4'hb
`define SRAD_TGT_GAIN        4'hc
`endif

/* core/srad_decoder.v */
`timescale 1ns/1ps
`include "srad_consts.vh"
// Notes on behaviour
// - latest command steers the next data phase
// - command valid only when bit 7 low
// - bit 6 zero writes, one reads
// - bits 5:0 pick fixed registers by code
// - channel and setup codes, low bits index
// - filter, offset, gain codes, low bits index
// - command register at zero, resets zero, write-only
// - status reads 8 bits, reset 0x80, wait flag
module srad_decoder (
  // clock and reset
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       clk_en,
  // byte stream from serial front end (same clock)
  input  wire       byte_valid,
  input  wire [7:0] byte_data,
  input  wire       frame_end,
  // conversion events
  input  wire       new_result,
  // decoded data phase
  output reg        phase_active_q,
  output reg        phase_read_q,
  output reg  [3:0] phase_target_q,
  output reg  [1:0] phase_index_q,
  output reg        data_write_q,
  output reg  [7:0] data_byte_q,
  output reg        status_read_q,
  output reg  [7:0] status_q,
  output reg        bad_cmd_q
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [0:0] ST_CMD  = 1'b0;
  localparam [0:0] ST_DATA = 1'b1;

  reg [0:0] state_q;
  reg [7:0] cmd_q;  // write-only: no path drives it back out
  reg [3:0] tgt_d;

  // ----------------------------------------
  // target decode
  // ----------------------------------------
  always @* begin
    case (byte_data[`SRAD_SEL_HI:`SRAD_SEL_LO])
      `SRAD_SEL_STATUS:   tgt_d = `SRAD_TGT_STATUS;
      `SRAD_SEL_ADCMODE:  tgt_d = `SRAD_TGT_ADCMODE;
      `SRAD_SEL_IFMODE:   tgt_d = `SRAD_TGT_IFMODE;
      `SRAD_SEL_CHECKSUM: tgt_d = `SRAD_TGT_CHECKSUM;
      `SRAD_SEL_DATA:     tgt_d = `SRAD_TGT_DATA;
      `SRAD_SEL_GPIO:     tgt_d = `SRAD_TGT_GPIO;
      `SRAD_SEL_ID:       tgt_d = `SRAD_TGT_ID;
      default: begin
        // banked codes: upper four bits pick the bank, low two the index;
        // bank bases all set bit 4 or 5, which fixed codes 0-7 never do, so no extra zero test on bits 3:2
        case (byte_data[5:2])
          `SRAD_SEL_CH_BASE:    tgt_d = `SRAD_TGT_CHANNEL;
          `SRAD_SEL_SETUP_BASE: tgt_d = `SRAD_TGT_SETUP;
          `SRAD_SEL_FILT_BASE:  tgt_d = `SRAD_TGT_FILTER;
          `SRAD_SEL_OFFS_BASE:  tgt_d = `SRAD_TGT_OFFSET;
          `SRAD_SEL_GAIN_BASE:  tgt_d = `SRAD_TGT_GAIN;
          default:              tgt_d = `SRAD_TGT_NONE;
        endcase
      end
    endcase
  end

  // ----------------------------------------
  // command and data phase sequencing
  // ----------------------------------------
  // a frame end drops back to command state, so a stale selection never
  // carries into the next transaction
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q        <= ST_CMD;
      cmd_q          <= `SRAD_CMD_RESET;
      phase_active_q <= 1'b0;
      phase_read_q   <= 1'b0;
      phase_target_q <= `SRAD_TGT_NONE;
      phase_index_q  <= 2'b00;
      data_write_q   <= 1'b0;
      data_byte_q    <= 8'h00;
      status_read_q  <= 1'b0;
      bad_cmd_q      <= 1'b0;
    end else if (clk_en) begin
      data_write_q  <= 1'b0;
      status_read_q <= 1'b0;
      bad_cmd_q     <= 1'b0;
      if (frame_end) begin
        state_q        <= ST_CMD;
        phase_active_q <= 1'b0;
      end else if (byte_valid) begin
        case (state_q)
          ST_CMD: begin
            // first byte of a transaction is always the command
            if (byte_data[`SRAD_CMD_GUARD_BIT] == 1'b0) begin
              cmd_q          <= byte_data;
              phase_read_q   <= byte_data[`SRAD_CMD_DIR_BIT];
              phase_target_q <= tgt_d;
              phase_index_q  <= byte_data[1:0];
              phase_active_q <= 1'b1;
              state_q        <= ST_DATA;
              status_read_q  <= byte_data[`SRAD_CMD_DIR_BIT] &&
                                (tgt_d == `SRAD_TGT_STATUS);
            end else begin
              bad_cmd_q <= 1'b1;
            end
          end
          ST_DATA: begin
            // unknown targets never raise a write strobe
            if (!phase_read_q && phase_target_q != `SRAD_TGT_NONE) begin
              data_write_q <= 1'b1;
              data_byte_q  <= byte_data;
            end
          end
          default: begin
            state_q <= ST_CMD;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // status register
  // ----------------------------------------
  // wait flag: a new result clears it, an active data read before the result
  // arrives sets it; a new result in the same cycle as a read wins
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= `SRAD_STATUS_RESET;
    end else if (clk_en) begin
      if (new_result) begin
        status_q[`SRAD_STATUS_WAIT_BIT] <= 1'b0;
      end else if (phase_active_q && phase_read_q &&
                   phase_target_q == `SRAD_TGT_DATA) begin
        status_q[`SRAD_STATUS_WAIT_BIT] <= 1'b1;
      end
    end
  end
endmodule // srad_decoder

/* sim/srad_host.sv */
`timescale 1ns/1ps
module srad_host (
  // clock
  input  wire       ref_clk,
  // byte stream
  output reg        byte_valid = 1'b0,
  output reg  [7:0] byte_data  = 8'h00,
  output reg        frame_end  = 1'b0
);
  // a released data line shows the inverse, not the old byte
  task put(input logic [7:0] b);
    @(posedge ref_clk) #1 byte_valid = 1'b1;
    byte_data = b;
    @(posedge ref_clk) #1 byte_valid = 1'b0;
    byte_data = ~b;
  endtask
  task fin;
    @(posedge ref_clk) #1 frame_end = 1'b1;
    @(posedge ref_clk) #1 frame_end = 1'b0;
  endtask
endmodule // srad_host

/* sim/srad_chk_properties.sv */
`timescale 1ns/1ps
module srad_chk (
  // inputs, plus the data_byte_q and status_q outputs
  input wire       ref_clk, reset_n, clk_en, byte_valid, frame_end, new_result,
  input wire [7:0] byte_data, data_byte_q, status_q,
  // outputs
  input wire       phase_active_q, phase_read_q, data_write_q, status_read_q, bad_cmd_q,
  input wire [3:0] phase_target_q,
  input wire [1:0] phase_index_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire cmd = clk_en && byte_valid && !frame_end && !phase_active_q;
  wire dat = clk_en && byte_valid && !frame_end && phase_active_q;
  sequence s_cmd(c); cmd && byte_data == c; endsequence
  property p_guard; cmd && byte_data[7] |=> bad_cmd_q && !phase_active_q; endproperty
  a_guard: assert property (p_guard) else $error("guard not refused");
  property p_dir; cmd && !byte_data[7] |=> phase_active_q && phase_read_q == $past(byte_data[6]); endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_fix; s_cmd(8'h04) |=> phase_target_q == 4'h5; endproperty
  a_fix: assert property (p_fix) else $error("data target wrong");
  property p_bank; s_cmd(8'h12) |=> phase_target_q == 4'h8 && phase_index_q == 2'h2; endproperty
  a_bank: assert property (p_bank) else $error("bank target wrong");
  property p_unk; phase_target_q == 4'h0 |-> !data_write_q; endproperty
  a_unk: assert property (p_unk) else $error("write to no target");
  property p_stat; s_cmd(8'h40) |=> status_read_q && phase_target_q == 4'h1; endproperty
  a_stat: assert property (p_stat) else $error("status read missed");
  property p_new; clk_en && new_result |=> !status_q[7]; endproperty
  a_new: assert property (p_new) else $error("wait flag not cleared");
  property p_hold; phase_active_q && clk_en && !frame_end |=> phase_active_q && $stable(phase_target_q); endproperty
  a_hold: assert property (p_hold) else $error("phase lost");
  property p_wr; dat && !phase_read_q && phase_target_q != 0 |=> data_write_q && data_byte_q == $past(byte_data); endproperty
  a_wr: assert property (p_wr) else $error("data write wrong");
endmodule // srad_chk
bind srad_decoder srad_chk u_chk (.*);

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  reg ref_clk = 0, reset_n = 0, new_result = 0, clk_en = 1;
  wire bv, fe, pa, pr, dw, sr, bc;
  wire [7:0] bd, db, st;
  wire [3:0] pt;
  wire [1:0] pi;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  // {command byte, expected target class}
  localparam logic [12:0][11:0] TBL = {12'h012, 12'h023, 12'h034, 12'h045, 12'h066, 12'h077,
    12'h128, 12'h219, 12'h2aa, 12'h33b, 12'h38c, 12'h050, 12'h3f0};
  always #2.5 ref_clk = ~ref_clk;
  srad_host host (.ref_clk(ref_clk), .byte_valid(bv), .byte_data(bd), .frame_end(fe));
  srad_decoder dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .byte_valid(bv),
    .byte_data(bd), .frame_end(fe), .new_result(new_result), .phase_active_q(pa),
    .phase_read_q(pr), .phase_target_q(pt), .phase_index_q(pi), .data_write_q(dw),
    .data_byte_q(db), .status_read_q(sr), .status_q(st), .bad_cmd_q(bc));
  task chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling well above the hundred or so cycles the tests need
  always @(posedge ref_clk) if (++cyc == 2000) begin
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1;
    chk("status", 8'h80, st);
    host.put(8'h81);
    chk("bad", 1, bc);
    chk("act", 0, pa);
    host.fin;
    clk_en = 0;
    host.put(8'h01);
    chk("frozen", 0, pa);
    clk_en = 1;
    $display("test guard done");
    for (int i = 12; i >= 0; i--) begin
      host.put(TBL[i][11:4]);
      chk("tgt", TBL[i][3:0], pt);
      chk("idx", TBL[i][5:4], pi);
      host.put(i[7:0]);
      chk("wr", TBL[i][3:0] != 0, dw);
      if (TBL[i][3:0] != 0) chk("dbyte", i[7:0], db);
      host.fin;
      chk("act", 0, pa);
    end
    $display("test decode done");
    host.put(8'h40);
    chk("srd", 1, sr);
    chk("rd", 1, pr);
    host.fin;
    @(posedge ref_clk) #1 new_result = 1;
    @(posedge ref_clk) #1 new_result = 0;
    chk("wait", 0, st[7]);
    host.put(8'h44);
    @(posedge ref_clk) #1;
    chk("wait set", 1, st[7]);
    host.fin;
    reset_n = 0;
    @(posedge ref_clk) #1 reset_n = 1;
    chk("status", 8'h80, st);
    $display("test status done");
    complete_run;
  end
endmodule // tb
